/* rtl/dio_map.svh */
// Register offsets, field positions, reset values for the digital I/O port.
// Assumes inclusion by the port module only.
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DIO_CFG_OFS 4'h0
`define DIO_CFG_RST 16'h0000
`define DIO_CFG_WMASK 16'h73ff
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DIO_BITDIR_LSB 0
`define DIO_BYTEA_DIR 8
`define DIO_BYTEB_DIR 9
`define DIO_LSEL_LSB 12
`define DIO_LSEL_MSB 14
// ----------------------------------------
// Light-select codes
// ----------------------------------------
`define DIO_LSEL_BITS 3'h0
`define DIO_LSEL_BYTEA 3'h4
`define DIO_LSEL_BYTEB 3'h5

`endif

/* rtl/dio_pkg.sv */
// Types shared by the digital I/O port.
// Assumes dio_map.svh is on the include path.
package dio_pkg;
   // Eight-bit pin group: output data and output enable (low = driving)
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_b;
   } dio_pins_t;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } dio_req_t;
endpackage : dio_pkg

/* rtl/dio_sync.sv */
// Two-flop synchroniser bank for external pin levels.
// Assumes inputs come from pins outside the sys_clk domain.
`timescale 1ns/100ps
module dio_sync #(
   parameter int WIDTH = 24
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   if (WIDTH < 1) begin : g_width_chk
      $error("dio_sync: WIDTH must be positive");
   end

   // First stage read only by the second stage
   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;
endmodule : dio_sync

/* rtl/dio_port.sv */
// Digital I/O port: direction config register, line drivers, indicator lights.
// Assumes a single-cycle register port on sys_clk and pins outside the domain.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/100ps
`include "dio_map.svh"
// Operation
// - Config bits 0-7 set each single-bit line direction; one means output.
// - Bit 8 drives byte A, bit 9 byte B, as whole byte outputs.
// - Config resets to zero so every line starts as input.
// - Code 000 makes lights follow single-bit line levels.
// - Code 100 makes lights show byte A levels.
// - Code 101 makes lights show byte B levels.
module dio_port #(
   parameter int NBITS = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire dio_pkg::dio_req_t req,
   output logic [15:0] rdata,
   // Single-bit lines
   input wire logic [7:0] bit_in,
   output dio_pkg::dio_pins_t bit_pins,
   // Byte ports, accessed as one word
   input wire logic [15:0] word_in,
   input wire logic [15:0] word_out,
   output logic [15:0] word_dout,
   output logic [15:0] word_oe_b,
   // Single-bit line output data
   input wire logic [7:0] bit_out,
   // Indicator lights
   output logic [7:0] lights
);
   import dio_pkg::*;

   // Lines and lights are wired for exactly eight single-bit lines
   // A wider bank would need a wider config register, which does not exist
   if (NBITS != 8) begin : g_nbits_chk
      $error("dio_port: only eight single-bit lines supported");
   end

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // One mapped register; shared so logic and checks decode alike
   function automatic logic cfg_hit(input logic [3:0] addr);
      return addr == `DIO_CFG_OFS;
   endfunction : cfg_hit

   // ----------------------------------------
   // Pin input synchronisers
   // ----------------------------------------
   logic [23:0] pins_sync;

   dio_sync #(.WIDTH(24)) u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .async_in({word_in, bit_in}),
      .sync_out(pins_sync)
   );

   // ----------------------------------------
   // Configuration register
   // ----------------------------------------
   logic [15:0] cfg_r;
   logic [15:0] cfg_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;

   // Unused bits masked on write so they always read zero
   always_comb begin
      cfg_nxt = cfg_r;
      rdata_nxt = 16'h0000;
      if (req.wr && cfg_hit(req.addr)) begin
         cfg_nxt = req.wdata & `DIO_CFG_WMASK;
      end
      // Read data come from a register, one cycle after the strobe
      if (req.rd && cfg_hit(req.addr)) begin
         rdata_nxt = cfg_r;
      end
   end

   // Reset to all inputs protects attached equipment
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= `DIO_CFG_RST;
         rdata_r <= 16'h0000;
      end else begin
         cfg_r <= cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;

   // ----------------------------------------
   // Line drivers
   // ----------------------------------------
   logic [7:0] bit_dout_r;
   logic [7:0] bit_dout_nxt;
   logic [15:0] word_dout_r;
   logic [15:0] word_dout_nxt;

   // Output data registered; bytes move together as one word
   always_comb begin
      bit_dout_nxt = bit_out;
      word_dout_nxt = word_out;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_dout_r <= 8'h00;
         word_dout_r <= 16'h0000;
      end else begin
         bit_dout_r <= bit_dout_nxt;
         word_dout_r <= word_dout_nxt;
      end
   end

   // Enables are active low: a set direction bit drives the line
   assign bit_pins = '{dout: bit_dout_r, oe_b: ~cfg_r[`DIO_BITDIR_LSB +: 8]};
   assign word_dout = word_dout_r;
   assign word_oe_b = {{8{~cfg_r[`DIO_BYTEB_DIR]}}, {8{~cfg_r[`DIO_BYTEA_DIR]}}};

   // ----------------------------------------
   // Indicator light select
   // ----------------------------------------
   logic [7:0] lights_r;
   logic [7:0] lights_nxt;
   logic [2:0] lsel;

   assign lsel = cfg_r[`DIO_LSEL_MSB:`DIO_LSEL_LSB];

   // Lights show sensed pin levels, so they also reflect driven outputs
   always_comb begin
      case (lsel)
         `DIO_LSEL_BYTEA: lights_nxt = pins_sync[15:8];
         `DIO_LSEL_BYTEB: lights_nxt = pins_sync[23:16];
         `DIO_LSEL_BITS: lights_nxt = pins_sync[7:0];
         default: lights_nxt = pins_sync[7:0];
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lights_r <= 8'h00;
      end else begin
         lights_r <= lights_nxt;
      end
   end

   assign lights = lights_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (cfg_r[15] == 1'b0) && (cfg_r[11:10] == 2'b00))
      else $error("reserved config bits not zero");

   a_bit_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req.wr && req.addr == `DIO_CFG_OFS) |=> (bit_pins.oe_b == ~$past(req.wdata[7:0])))
      else $error("single-bit direction mismatch");

   a_byte_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req.wr && req.addr == `DIO_CFG_OFS) |=>
         (word_oe_b[0] == ~$past(req.wdata[8])) && (word_oe_b[8] == ~$past(req.wdata[9])))
      else $error("byte direction mismatch");

   a_reset_input: assert property (@(posedge sys_clk)
      $rose(rst_b) |-> (bit_pins.oe_b == 8'hff) && (word_oe_b == 16'hffff))
      else $error("lines not inputs after reset");

   a_light_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (lsel == 3'h0) |=> (lights == $past(pins_sync[7:0])))
      else $error("lights not following single-bit lines");

   a_light_bytea: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (lsel == 3'h4) |=> (lights == $past(pins_sync[15:8])))
      else $error("lights not following byte A");

   a_light_byteb: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (lsel == 3'h5) |=> (lights == $past(pins_sync[23:16])))
      else $error("lights not following byte B");

   a_read_back: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (req.wr && req.addr == `DIO_CFG_OFS) ##1 (req.rd && req.addr == `DIO_CFG_OFS && !req.wr)
         |=> (rdata == ($past(req.wdata, 2) & 16'h73ff)))
      else $error("config read back mismatch");

   // ----------------------------------------
   // Checks on idle behaviour, output data and light fallback
   // ----------------------------------------
   // Read data must drop back to zero once its cycle is over
   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !(req.rd && cfg_hit(req.addr)) |=> (rdata == 16'h0000))
      else $error("read data not zero outside a read");

   // Unmapped or absent writes must leave the setting alone
   a_cfg_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !(req.wr && cfg_hit(req.addr)) |=> $stable(cfg_r))
      else $error("config changed without a write");

   // Output data lag the requested data by one register; not across reset
   a_bit_dout: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b |=> (bit_pins.dout == $past(bit_out)))
      else $error("single-bit output data mismatch");

   // Both bytes move together, never one without the other
   a_word_dout: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rst_b |=> (word_dout == $past(word_out)))
      else $error("byte word output data mismatch");

   // Any code outside the two byte codes shows the single-bit lines
   a_light_fallback: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (lsel != 3'h4 && lsel != 3'h5) |=> (lights == $past(pins_sync[7:0])))
      else $error("lights not falling back to single-bit lines");
endmodule : dio_port

/* dv/dio_ext.sv */
// External equipment on the digital I/O lines.
// Assumes oe_b low means the port drives the line.
`timescale 1ns/100ps
module dio_ext (
   // Port side
   input wire dio_pkg::dio_pins_t bit_pins,
   input wire logic [15:0] word_dout,
   input wire logic [15:0] word_oe_b,
   // Equipment levels
   input wire logic [7:0] eq_bits,
   input wire logic [15:0] eq_word,
   // Resolved pin levels
   output logic [7:0] bit_in,
   output logic [15:0] word_in
);
   import dio_pkg::*;
   // Port wins while enabled, so outputs loop back to the lights
   assign bit_in = (bit_pins.dout & ~bit_pins.oe_b) | (eq_bits & bit_pins.oe_b);
   assign word_in = (word_dout & ~word_oe_b) | (eq_word & word_oe_b);
endmodule : dio_ext

/* dv/dio_port_bench.sv */
// Self-checking bench for the digital I/O port.
// Assumes dio_port and dio_ext are compiled first.
`timescale 1ns/100ps
module dio_port_bench;
   import dio_pkg::*;
   logic sys_clk, rst_b;
   dio_req_t req;
   dio_pins_t bit_pins;
   logic [15:0] rdata, word_in, word_out, word_dout, word_oe_b, eq_word, rd_val;
   logic [7:0] bit_in, bit_out, eq_bits, lights;
   int mismatches, checks;
   dio_port uut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .bit_in(bit_in),
      .bit_pins(bit_pins), .word_in(word_in), .word_out(word_out), .word_dout(word_dout),
      .word_oe_b(word_oe_b), .bit_out(bit_out), .lights(lights));
   dio_ext ext (.bit_pins(bit_pins), .word_dout(word_dout), .word_oe_b(word_oe_b),
      .eq_bits(eq_bits), .eq_word(eq_word), .bit_in(bit_in), .word_in(word_in));
   // ------------------------------
   // Clock and tasks
   // ------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   // One-cycle strobes; slave never stalls
   task automatic cfg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : cfg_write
   // Data stand only in the cycle after the strobe
   task automatic cfg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask : cfg_read
   // Write then read with no idle cycle between the strobes
   task automatic cfg_write_read(input logic [3:0] a, input logic [15:0] d,
      output logic [15:0] q);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req <= '0;
      #1 q = rdata;
   endtask : cfg_write_read
   // Four edges cover two sync flops plus the light register
   task automatic lamp(input logic [15:0] cfg, input logic [7:0] exp);
      cfg_write(4'h0, cfg);
      repeat (4) @(posedge sys_clk);
      #1 check("lights", {8'h00, exp}, {8'h00, lights});
   endtask : lamp
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      rst_b = 1'b0;
      req = '0;
      bit_out = 8'h00;
      word_out = 16'h0000;
      eq_bits = 8'h3c;
      eq_word = 16'hc35a;
      mismatches = 0;
      checks = 0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      cfg_read(4'h0, rd_val);
      check("cfg", 16'h0000, rd_val);
      check("bit oe_b", 16'h00ff, {8'h00, bit_pins.oe_b});
      check("word oe_b", 16'hffff, word_oe_b);
      lamp(16'h0000, 8'h3c);
      lamp(16'h4000, 8'h5a);
      lamp(16'h5000, 8'hc3);
      lamp(16'h7000, 8'h3c);
      lamp(16'h1000, 8'h3c);
      cfg_write_read(4'h0, 16'hffff, rd_val);
      check("cfg mask", 16'h73ff, rd_val);
      @(posedge sys_clk);
      #1 check("rdata idle", 16'h0000, rdata);
      cfg_write(4'h3, 16'h0000);
      cfg_read(4'h3, rd_val);
      check("unmapped", 16'h0000, rd_val);
      cfg_read(4'h0, rd_val);
      check("cfg kept", 16'h73ff, rd_val);
      cfg_write(4'h0, 16'h0105);
      @(posedge sys_clk);
      bit_out <= 8'hf0;
      word_out <= 16'h1234;
      #1 check("bit oe_b", 16'h00fa, {8'h00, bit_pins.oe_b});
      check("word oe_b", 16'hff00, word_oe_b);
      lamp(16'h00ff, 8'hf0);
      check("bit dout", 16'h00f0, {8'h00, bit_pins.dout});
      check("word dout", 16'h1234, word_dout);
      lamp(16'h4100, 8'h34);
      lamp(16'h5100, 8'hc3);
      lamp(16'h52ff, 8'h12);
      // Mid-run reset must drop every driver again
      @(posedge sys_clk);
      rst_b <= 1'b0;
      @(posedge sys_clk);
      rst_b <= 1'b1;
      cfg_read(4'h0, rd_val);
      check("cfg", 16'h0000, rd_val);
      check("bit oe_b", 16'h00ff, {8'h00, bit_pins.oe_b});
      check("word oe_b", 16'hffff, word_oe_b);
      summarize();
   end
endmodule : dio_port_bench
